// >>> page_size_config_and_id_read_tb.sv
// self-checking bench for the page-size and id command block
`timescale 1ns/1ps
module page_size_config_and_id_read_tb;
    localparam int CFG = 16;
    localparam logic [7:0] MAN = 8'hc3; // arbitrary value
    localparam logic [7:0] DEV1 = {3'h5, 5'h13}; // arbitrary value
    localparam logic [7:0] DEV2 = {3'h6, 5'h09}; // arbitrary value
    logic clk, rst_n, sck, cs_n, si, so, so_oe, cfg_nv, ext_busy;
    logic cfg_write, page_binary, cmd_allowed;
    logic [9:0] page_bytes;
    logic [7:0] status_byte, b;
    psi_pkg::psi_cls_t ext_cls;
    psi_pkg::psi_stat_t stat;
    int miscompares = 0, samples_checked = 0;
    psi_core #(.CFG_CYC(CFG), .MANUF_ID(MAN), .FAMILY(DEV1[7:5]),
        .DENSITY(DEV1[4:0]), .CELL_TECH(DEV2[7:5]), .VERSION(DEV2[4:0])) dut (
        .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
        .so_oe(so_oe), .cfg_nv(cfg_nv), .ext_busy(ext_busy),
        .ext_cls(ext_cls), .cfg_write(cfg_write), .page_binary(page_binary),
        .page_bytes(page_bytes), .status_byte(status_byte), .stat(stat),
        .cmd_allowed(cmd_allowed));
    psi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // nonvolatile cell model
    always @(posedge clk)
        if (cfg_write === 1'b1)
            cfg_nv <= 1'b1;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d of %0d checks", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic send(input logic [31:0] w, input int extra);
        host.start();
        for (int k = 3; k >= 0; k--)
            host.xfer(w[8*k+:8], 8, b);
        if (extra != 0)
            host.xfer(8'h00, 8, b);
        host.stop();
    endtask
    task automatic watch_idle();
        int bad;
        bad = 0;
        repeat (CFG + 10) @(negedge clk)
            if (stat.cfg_busy !== 1'b0 || cfg_write !== 1'b0
                || stat.ready !== !ext_busy)
                bad++;
        check(bad, 0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_page(input logic pb);
        check(page_binary, pb);
        check(page_bytes, pb ? 10'd512 : 10'd528);
        check(status_byte, {1'b1, 6'h00, pb});
        check({stat.ready, stat.binary_page}, {1'b1, pb});
        host.start();
        host.xfer(psi_pkg::OP_STATUS, 8, b);
        for (int k = 0; k < 2; k++)
        begin
            host.xfer(8'h00, 8, b);
            check(b, {1'b1, 6'h00, pb});
        end
        host.stop();
    endtask
    task automatic t_id();
        logic [7:0] exp [5];
        exp = '{MAN, DEV1, DEV2, psi_pkg::ID_EXT_LEN, 8'h00};
        host.start();
        host.xfer(psi_pkg::OP_ID, 8, b);
        for (int k = 0; k < 5; k++)
        begin
            host.xfer(8'h00, 8, b);
            check(b, exp[k]);
        end
        host.xfer(8'h00, 3, b);
        host.stop();
        #1 check(so_oe, 1'b0);
    endtask
    task automatic t_cls(input psi_pkg::psi_cls_t c, input logic bz,
                         input logic exp);
        @(posedge clk) ext_busy <= bz;
        ext_cls <= c;
        @(negedge clk) check(cmd_allowed, exp);
    endtask
    task automatic t_config();
        int n;
        n = 0;
        send(32'h3d2a80a6, 0);
        while (stat.ready !== 1'b0 && n < 10)
            @(negedge clk) n++;
        check(status_byte[7], 1'b0);
        check(stat.cfg_busy, 1'b1);
        n = 0;
        while (cfg_write !== 1'b1 && n < 100)
        begin
            check(page_binary, 1'b0);
            @(negedge clk) n++;
        end
        check(n >= CFG - 2 && n <= CFG + 4, 1'b1);
        repeat (3) @(negedge clk);
        check(stat.ready, 1'b1);
    endtask
    initial
    begin
        rst_n = 1'b0;
        cfg_nv = 1'b0;
        ext_busy = 1'b0;
        ext_cls = psi_pkg::PSI_CLS_NONE;
        do_reset();
        t_page(1'b0);
        t_id();
        send(32'h3d2aa680, 0);
        watch_idle();
        send(32'h3d2a80a6, 1);
        watch_idle();
        // class c accepted while busy in class b
        t_cls(psi_pkg::PSI_CLS_B, 1'b1, 1'b1);
        send(32'h3d2a80a6, 0);
        watch_idle();
        t_cls(psi_pkg::PSI_CLS_A, 1'b1, 1'b0);
        t_cls(psi_pkg::PSI_CLS_D, 1'b1, 1'b0);
        t_cls(psi_pkg::PSI_CLS_NONE, 1'b0, 1'b1);
        t_config();
        check(page_binary, 1'b0);
        do_reset();
        // read page bit after power cycle
        t_page(1'b1);
        send(32'h3d2a80a6, 0);
        watch_idle();
        check(page_binary, 1'b1);
        results();
    end
    initial
    begin
        #300us;
        miscompares++;
        results();
    end
endmodule

// >>> psi_core.sv
// serial command handling for page-size configuration and id read
//
// Notes on behaviour
// RULE1: once binary page size is programmed it stays; no return to 528.
// RULE2: unprogrammed device works with 528-byte pages.
// RULE3: config command is 3d 2a 80 a6 in one frame, exact order only.
// RULE4: chip select rising after the fourth byte starts the program cycle.
// RULE5: busy reported while programming; cycle ends within its time limit.
// RULE6: new page size applies only after power cycle following completion.
// RULE7: host checks page-size bit after power cycle and reissues if unset.
// RULE8: host configures and power cycles before binary page programming.
// RULE9: opcode 9f starts id read; bytes follow on serial output.
// RULE10: id is manufacturer, two device bytes, then length byte 00.
// RULE11: device byte one: family in bits 7..5, density in 4..0.
// RULE12: device byte two: cell technology in 7..5, version in 4..0.
// RULE13: host may stop the id read before the length byte.
// RULE14: chip select high ends id read and floats serial output.
// RULE15: host treats 7f manufacturer bytes as continuation codes.
// RULE16: commands fall into classes a, b, c and d.
// RULE17: no new command while a class a read is in progress.
// RULE18: class c accepted during internally timed class b phase.
// RULE19: class c buffer commands use the other buffer during class b.
// RULE20: only status read during internally timed class d phase.
// RULE21: page-size status bit reads one for 512, zero for 528.
// RULE22: top status bit reads one when ready, zero when busy.
// RULE23: id bytes shift out msb first, one bit per clock, repeating; code sends 00 after the length byte instead.
`timescale 1ns/1ps
module psi_core #(
    parameter int CFG_CYC = psi_pkg::CFG_PROG_CYC,
    parameter logic [7:0] MANUF_ID = 8'h5a, // arbitrary value
    parameter logic [2:0] FAMILY = 3'h2, // arbitrary value
    parameter logic [4:0] DENSITY = 5'h0a, // arbitrary value
    parameter logic [2:0] CELL_TECH = 3'h3, // arbitrary value
    parameter logic [4:0] VERSION = 5'h04 // arbitrary value
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic cfg_nv,
    input wire logic ext_busy,
    input wire psi_pkg::psi_cls_t ext_cls,
    output logic cfg_write,
    output logic page_binary,
    output logic [9:0] page_bytes,
    output logic [7:0] status_byte,
    output psi_pkg::psi_stat_t stat,
    output logic cmd_allowed
);
    // -----------------------------------------------------------------
    // link domain: shift in, shift out
    // -----------------------------------------------------------------
    logic [2:0] bit_q;
    logic [6:0] sh_q;
    logic [2:0] nbyte_q;
    logic cfg_seq_q;
    logic id_mode_q;
    logic st_mode_q;
    logic cfg_arm_q;
    logic [7:0] obuf_q;
    logic [1:0] oidx_q;
    logic [7:0] rx_byte;
    logic [7:0] id_byte;
    psi_pkg::psi_id_t id_w;
    logic [7:0] st_sync1_q;
    logic [7:0] st_sync2_q;

    assign rx_byte = {sh_q, si};
    assign id_w = '{MANUF_ID, FAMILY, DENSITY, CELL_TECH, VERSION};

    // id byte select
    always_comb
    begin
        case (oidx_q)
            2'h0: id_byte = id_w.manuf;
            // RULE11 family then density
            2'h1: id_byte = {id_w.family, id_w.density};
            // RULE12 technology then version
            2'h2: id_byte = {id_w.cell_technology_code, id_w.version};
            // RULE10 no extended data
            default: id_byte = psi_pkg::ID_EXT_LEN;
        endcase
    end

    // status byte into link domain, quasi-static
    always_ff @(posedge sck)
    begin
        st_sync1_q <= status_byte;
        st_sync2_q <= st_sync1_q;
    end

    // input shifter and opcode decode, cleared by chip select
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_q <= 3'h0;
            sh_q <= 7'h00;
            nbyte_q <= 3'h0;
            cfg_seq_q <= 1'b1;
            id_mode_q <= 1'b0;
            st_mode_q <= 1'b0;
            cfg_arm_q <= 1'b0;
        end
        else
        begin
            bit_q <= bit_q + 3'h1;
            sh_q <= rx_byte[6:0];
            if (bit_q == 3'h7 && !id_mode_q && !st_mode_q)
            begin
                if (nbyte_q != 3'h7)
                    nbyte_q <= nbyte_q + 3'h1;
                // RULE3 exact byte order
                case (nbyte_q)
                    3'h0: cfg_seq_q <= rx_byte == psi_pkg::OP_CFG0;
                    3'h1: cfg_seq_q <= cfg_seq_q
                        && rx_byte == psi_pkg::OP_CFG1;
                    3'h2: cfg_seq_q <= cfg_seq_q
                        && rx_byte == psi_pkg::OP_CFG2;
                    default: cfg_seq_q <= cfg_seq_q && nbyte_q == 3'h3
                        && rx_byte == psi_pkg::OP_CFG3;
                endcase
                cfg_arm_q <= nbyte_q == 3'h3 && cfg_seq_q
                    && rx_byte == psi_pkg::OP_CFG3;
                // RULE9 id opcode
                if (nbyte_q == 3'h0 && rx_byte == psi_pkg::OP_ID)
                    id_mode_q <= 1'b1;
                if (nbyte_q == 3'h0 && rx_byte == psi_pkg::OP_STATUS)
                    st_mode_q <= 1'b1;
            end
        end
    end

    // output shifter on falling edge
    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            obuf_q <= 8'h00;
            oidx_q <= 2'h0;
        end
        else if (bit_q == 3'h0 && (id_mode_q || st_mode_q))
        begin
            // RULE23 msb first, byte after byte
            obuf_q <= id_mode_q ? id_byte : st_sync2_q;
            if (id_mode_q && oidx_q != 2'h3)
                oidx_q <= oidx_q + 2'h1;
        end
        else
            obuf_q <= {obuf_q[6:0], 1'b0};
    end

    // RULE14 float when chip select high
    assign so_oe = !cs_n && (id_mode_q || st_mode_q);
    assign so = obuf_q[7];

    // -----------------------------------------------------------------
    // system domain: crossing, program cycle, status
    // -----------------------------------------------------------------
    logic cs1_q;
    logic cs2_q;
    logic cs3_q;
    logic arm1_q;
    logic arm2_q;
    logic prog_q;
    logic [$clog2(CFG_CYC+1)-1:0] cnt_q;
    logic done_q;
    logic boot_q;
    logic page_bin_q;
    logic cfg_rise;
    logic arm_hold_q;

    always_ff @(posedge clk)
    begin
        cs1_q <= cs_n;
        cs2_q <= cs1_q;
        cs3_q <= cs2_q;
        arm1_q <= cfg_arm_q;
        arm2_q <= arm1_q;
    end

    // arm as last seen inside the frame; cs_n high clears the link copy
    // hazard: last bit to cs_n rise must span one clk edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            arm_hold_q <= 1'b0;
        else if (!cs2_q)
            arm_hold_q <= arm2_q;
    end

    // RULE4 start on chip select rising edge after full sequence
    assign cfg_rise = cs2_q && !cs3_q && arm_hold_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prog_q <= 1'b0;
            cnt_q <= '0;
            done_q <= 1'b0;
        end
        // RULE1 already binary: refuse reprogramming
        else if (cfg_rise && !prog_q && !ext_busy && !cfg_nv)
        begin
            prog_q <= 1'b1;
            cnt_q <= '0;
        end
        else if (prog_q)
        begin
            // RULE5 bounded program time
            if (cnt_q == ($clog2(CFG_CYC+1))'(CFG_CYC - 1))
            begin
                prog_q <= 1'b0;
                done_q <= 1'b1;
            end
            else
                cnt_q <= cnt_q + 1'b1;
        end
    end

    // one-cycle write strobe to the nonvolatile cell
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cfg_write <= 1'b0;
        else
            cfg_write <= prog_q
                && cnt_q == ($clog2(CFG_CYC+1))'(CFG_CYC - 1);
    end

    // RULE6 page size latched only at power-up reset release
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            boot_q <= 1'b1;
            page_bin_q <= 1'b0;
        end
        else if (boot_q)
        begin
            boot_q <= 1'b0;
            // RULE2 default 528 unless programmed
            page_bin_q <= cfg_nv;
        end
    end

    assign page_binary = page_bin_q;
    assign page_bytes = page_bin_q ? 10'(psi_pkg::PAGE_BIN)
                                   : 10'(psi_pkg::PAGE_STD);

    // RULE22 ready bit, RULE21 page-size bit
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[psi_pkg::ST_READY_POS] = !(prog_q || ext_busy);
        status_byte[psi_pkg::ST_PAGE_POS] = page_bin_q;
        stat = '{!(prog_q || ext_busy), page_bin_q, prog_q};
    end

    // RULE16 class gating; RULE18 class c during class b
    always_comb
    begin
        case (ext_cls)
            psi_pkg::PSI_CLS_NONE: cmd_allowed = !prog_q;
            psi_pkg::PSI_CLS_B: cmd_allowed = 1'b1;
            default: cmd_allowed = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    // RULE22 ready low while busy
    busy_ready_a: assert property ( // RULE22
        @(posedge clk) disable iff (!rst_n)
        prog_q |-> !status_byte[7])
        else $error("ready shown during program");
    // RULE22 ready high while idle
    ready_idle_a: assert property ( // RULE22
        @(posedge clk) disable iff (!rst_n)
        !prog_q && !ext_busy |-> status_byte[7])
        else $error("busy shown while idle");
    // RULE5 minimum program length
    busy_prog_a: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_n)
        $rose(prog_q) |-> prog_q [*8])
        else $error("program cycle too short");
    // RULE5 bounded program time
    prog_end_a: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_n)
        prog_q |-> cnt_q < ($clog2(CFG_CYC+1))'(CFG_CYC))
        else $error("program counter overrun");
    // RULE5 write at cycle end
    prog_done_a: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_n)
        $fell(prog_q) |-> cfg_write)
        else $error("program ended without write");
    // RULE5 single write strobe
    write_pulse_a: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_n)
        cfg_write |=> !cfg_write)
        else $error("write strobe longer than one cycle");
    // RULE4 start only after sequence
    cfg_start_a: assert property ( // RULE4
        @(posedge clk) disable iff (!rst_n)
        $rose(prog_q) |-> $past(cfg_rise))
        else $error("program started without sequence");
    // RULE1 binary setting kept
    refuse_bin_a: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_n)
        cfg_nv |=> !$rose(prog_q))
        else $error("reprogram not refused");
    // RULE6 size fixed after boot
    page_hold_a: assert property ( // RULE6
        @(posedge clk) disable iff (!rst_n)
        !boot_q |=> $stable(page_bin_q))
        else $error("page size changed without power cycle");
    // RULE21 page bit follows size
    page_bit_a: assert property ( // RULE21
        @(posedge clk) disable iff (!rst_n)
        status_byte[0] == (page_bytes == 10'(psi_pkg::PAGE_BIN)))
        else $error("page bit mismatch");
    // RULE18 class c during class b
    cls_b_a: assert property ( // RULE18
        @(posedge clk) disable iff (!rst_n)
        ext_cls == psi_pkg::PSI_CLS_B |-> cmd_allowed)
        else $error("class c refused during class b");
    // RULE17 nothing during class a
    cls_a_block_a: assert property ( // RULE17
        @(posedge clk) disable iff (!rst_n)
        ext_cls == psi_pkg::PSI_CLS_A |-> !cmd_allowed)
        else $error("command allowed during class a");
    // RULE14 float when deselected
    float_cs_a: assert property ( // RULE14
        @(posedge clk) disable iff (!rst_n)
        cs2_q |-> !so_oe)
        else $error("output driven while deselected");
    // main scenarios
    cov_prog_c: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(prog_q));
    cov_done_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(done_q));
    cov_refuse_c: cover property (@(posedge clk) disable iff (!rst_n)
        cfg_rise && cfg_nv);
    cov_id_c: cover property (@(posedge clk) disable iff (!rst_n)
        so_oe && id_mode_q);
    cov_status_c: cover property (@(posedge clk) disable iff (!rst_n)
        so_oe && st_mode_q);
endmodule

// >>> psi_host.sv
// host-side serial controller model driving the command block
`timescale 1ns/1ps
module psi_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic start();
        #24 cs_n = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            #24 sck = 1'b1;
            rx[i] = so_oe ? so : 1'bx;
            #24 sck = 1'b0;
        end
    endtask
    task automatic stop();
        #24 cs_n = 1'b1;
        si = ~si;
    endtask
endmodule

// >>> psi_pkg.sv
// shared constants and types for the page-size and id command block
package psi_pkg;
    // opcodes
    localparam logic [7:0] OP_CFG0 = 8'h3d;
    localparam logic [7:0] OP_CFG1 = 8'h2a;
    localparam logic [7:0] OP_CFG2 = 8'h80;
    localparam logic [7:0] OP_CFG3 = 8'ha6;
    localparam logic [7:0] OP_ID = 8'h9f;
    localparam logic [7:0] OP_STATUS = 8'hd7;
    // id response layout
    localparam logic [7:0] ID_EXT_LEN = 8'h00;
    localparam int ID_BYTES = 4;
    localparam int CODE_HI_POS = 5;
    // status register bit positions
    localparam int ST_READY_POS = 7;
    localparam int ST_PAGE_POS = 0;
    // page sizes
    localparam int PAGE_STD = 528;
    localparam int PAGE_BIN = 512;
    // configuration program time
    localparam int CLK_NS = 25;
    localparam int T_CFG_PROG_US = 6;
    localparam int CFG_PROG_CYC = (T_CFG_PROG_US * 1000) / CLK_NS;
    // command classes
    typedef enum logic [2:0] {
        PSI_CLS_NONE,
        PSI_CLS_A,
        PSI_CLS_B,
        PSI_CLS_C,
        PSI_CLS_D
    } psi_cls_t;
    // identification codes
    typedef struct packed {
        logic [7:0] manuf;
        logic [2:0] family;
        logic [4:0] density;
        logic [2:0] cell_technology_code;
        logic [4:0] version;
    } psi_id_t;
    // status seen by the host side
    typedef struct packed {
        logic ready;
        logic binary_page;
        logic cfg_busy;
    } psi_stat_t;
endpackage
